// ===== mp_pkg.sv
/*
 Shared constants and types for the memory protect / parity option and the
 CPU-side end that drives it. Assumes one 10 MHz clock shared by both ends.
*/
package mp_pkg;
   localparam int          ADDR_W          = 15;
   localparam int          WORD_W          = 16;
   localparam logic [5:0]  SELECT_CODE     = 6'h05;
   localparam logic [1:0]  INDIRECT_LIMIT  = 2'h3;
   localparam logic [1:0]  INDIRECT_RESET  = 2'h0;
   localparam int          PARITY_BIT      = 15;
   localparam logic [14:0] FENCE_RESET     = 15'h0000;
   localparam logic [14:0] LOWER_BOUND_JSB = 15'h0000;
   localparam logic [14:0] LOWER_BOUND_STD = 15'h0002;
   localparam int          CLK_HZ          = 10000000;
   localparam int          TPERIOD_NS      = 100;
   localparam int          TPERIOD_CYC     = (TPERIOD_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int          IOG_MIN_T       = 1;
   localparam int          IOG_MAX_T       = 5;
   typedef enum logic [2:0] {
      IO_NONE      = 3'h0,
      IO_SET_CTRL  = 3'h1,
      IO_SET_FLAG  = 3'h2,
      IO_CLR_FLAG  = 3'h3,
      IO_SKIP_SET  = 3'h4,
      IO_SKIP_CLR  = 3'h5,
      IO_LOAD_FNC  = 3'h6,
      IO_READ_VIO  = 3'h7
   } io_cmd_type;
   typedef enum logic [1:0] {
      HS_IDLE = 2'h0,
      HS_REQ  = 2'h1,
      HS_ACK  = 2'h3
   } irq_state_type;
endpackage

// ===== mp_link_if.sv
/*
 Link between the protect option and its CPU / memory / MEMORY_MANAGEMENT_UNIT side.
 Assumes both ends share clk_i. Strobes and statuses are active low
 except skip_flag_o-equivalent skip_flag, which is active high.
*/
`timescale 1ns/100ps
interface mp_link_if;
   logic        fetch_n;
   logic        halt_on_parity_n;
   logic        indirect_inc_n;
   logic        io_group_special_n;
   logic        ir_store_n;
   logic        mem_exp_violation_n;
   logic        protect_check_strobe_n;
   logic        parity_error_n;
   logic        mem_read_n;
   logic        dma_freeze_in_n;
   logic        int_ack_n;
   logic [2:0]  io_cmd;
   logic [5:0]  io_select;
   logic [14:0] m_bus;
   logic [15:0] s_bus_in;
   logic [15:0] s_bus_out;
   logic        control_n;
   logic        flag_n;
   logic        irq_n;
   logic        protect_check_in_progress_n;
   logic        indirect_interrupt_allow_n;
   logic        violation_n;
   logic        clear_parity_indicator_n;
   logic        skip_flag;
   modport device (
      input  fetch_n, halt_on_parity_n, indirect_inc_n, io_group_special_n, ir_store_n,
      input  mem_exp_violation_n, protect_check_strobe_n, parity_error_n, mem_read_n,
      input  dma_freeze_in_n, int_ack_n, io_cmd, io_select, m_bus, s_bus_in,
      output s_bus_out, control_n, flag_n, irq_n, protect_check_in_progress_n,
      output indirect_interrupt_allow_n, violation_n, clear_parity_indicator_n, skip_flag
   );
   modport host (
      output fetch_n, halt_on_parity_n, indirect_inc_n, io_group_special_n, ir_store_n,
      output mem_exp_violation_n, protect_check_strobe_n, parity_error_n, mem_read_n,
      output dma_freeze_in_n, int_ack_n, io_cmd, io_select, m_bus, s_bus_in,
      input  s_bus_out, control_n, flag_n, irq_n, protect_check_in_progress_n,
      input  indirect_interrupt_allow_n, violation_n, clear_parity_indicator_n, skip_flag
   );
endinterface

// ===== mp_device.sv
/*
 Memory protect and parity option, I/O select code 5.
 Assumes the CPU end holds each strobe for at least one clock.
*/
`timescale 1ns/100ps
module mp_device (
   input  wire logic                    clk_i,
   input  wire logic                    reset_i,
   mp_link_if.device                    link,
   output logic [mp_pkg::ADDR_W-1:0]    fence_o,
   output logic                         parity_enable_o
);
   import mp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic in_protected(input logic [14:0] a, input logic [14:0] f,
                                         input logic jsb);
      logic [14:0] lo;
      lo = jsb ? LOWER_BOUND_JSB : LOWER_BOUND_STD;
      in_protected = (a >= lo) && (a < f);
   endfunction

   logic [1:0]  ind_q, ind_d;
   logic        ctrl_q, ctrl_d, flag_q, flag_d, flagb_q, flagb_d;
   logic        paren_q, paren_d, parerr_q, parerr_d, vio15_q, vio15_d;
   logic        evr_q, evr_d, mpv_q, mpv_d, meflg_q, meflg_d;
   logic        jsb_q, jsb_d, iogsel_q, iogsel_d, rd_q, rd_d;
   logic        pci_q, pci_d, resp_q, resp_d, skip_q, skip_d, irq_q, irq_d;
   logic [14:0] fence_q, fence_d, mpvr_q, mpvr_d, pvr_q, pvr_d;
   logic [15:0] sout_q, sout_d;
   logic        sel, viol_now, par_evt, ack;
   logic        allow_q, allow_d;
   io_cmd_type  cmd;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      cmd      = io_cmd_type'(link.io_cmd);
      sel      = (link.io_select == SELECT_CODE);
      ack      = !link.int_ack_n && irq_q;
      par_evt  = !link.parity_error_n && link.halt_on_parity_n && paren_q;
      ind_d    = ind_q;
      ctrl_d   = ctrl_q;
      flag_d   = flag_q;
      flagb_d  = flagb_q;
      paren_d  = paren_q;
      parerr_d = parerr_q;
      vio15_d  = vio15_q;
      evr_d    = evr_q;
      mpv_d    = mpv_q;
      meflg_d  = meflg_q;
      jsb_d    = jsb_q;
      iogsel_d = iogsel_q;
      fence_d  = fence_q;
      mpvr_d   = mpvr_q;
      pvr_d    = pvr_q;
      sout_d   = sout_q;
      skip_d   = 1'b0;
      resp_d   = 1'b0;
      rd_d     = !link.mem_read_n;
      pci_d    = !link.protect_check_strobe_n;
      if (!link.indirect_inc_n && ind_q != INDIRECT_LIMIT) begin
         ind_d = ind_q + 2'h1;
      end
      if (!link.ir_store_n && link.dma_freeze_in_n) begin
         jsb_d    = (link.s_bus_in[14:11] == 4'h3);
         iogsel_d = (link.s_bus_in[15:12] == 4'h8) && (link.s_bus_in[10] == 1'b1);
      end
      viol_now = 1'b0;
      if (!link.protect_check_strobe_n && in_protected(link.m_bus, fence_q, jsb_q)) begin
         viol_now = 1'b1;
      end
      if (!link.mem_exp_violation_n) begin
         viol_now = 1'b1;
         meflg_d  = 1'b1;
      end
      if (!link.io_group_special_n && iogsel_q && !sel && link.io_select != 6'h01) begin
         viol_now = 1'b1;
      end
      if (!link.fetch_n) begin
         ind_d = INDIRECT_RESET;
         jsb_d = 1'b0;
         iogsel_d = 1'b0;
         if (evr_q) begin
            mpvr_d = link.m_bus;
         end
      end
      if (rd_q && link.mem_read_n && paren_q) begin
         pvr_d = link.m_bus;
      end
      if (sel) begin
         unique case (cmd)
            IO_SET_CTRL: begin
               ctrl_d   = 1'b1;
               parerr_d = 1'b0;
               if (!flag_q) begin
                  evr_d = 1'b1;
               end
            end
            IO_SET_FLAG: paren_d = 1'b1;
            IO_CLR_FLAG: begin
               paren_d = 1'b0;
               flag_d  = 1'b0;
               flagb_d = 1'b0;
            end
            IO_SKIP_SET: skip_d = meflg_q;
            IO_SKIP_CLR: skip_d = !meflg_q;
            IO_LOAD_FNC: fence_d = link.s_bus_in[14:0];
            IO_READ_VIO: sout_d = parerr_q ? {vio15_q, pvr_q} : {1'b0, mpvr_q};
            IO_NONE: begin
            end
         endcase
      end
      // After the command decode, so a violation beats a clear-flag in the same cycle
      if (ctrl_q && viol_now) begin
         mpv_d   = 1'b1;
         flagb_d = 1'b1;
         flag_d  = 1'b1;
         evr_d   = 1'b0;
      end
      if (par_evt) begin
         parerr_d = 1'b1;
         vio15_d  = 1'b1;
         paren_d  = 1'b0;
         pvr_d    = link.m_bus;
         flagb_d  = 1'b1;
         flag_d   = 1'b1;
      end
      if (ack) begin
         flag_d  = 1'b0;
         flagb_d = 1'b0;
         mpv_d   = 1'b0;
         ind_d   = INDIRECT_RESET;
         ctrl_d  = 1'b0;
         resp_d  = 1'b1;
      end
      if (!link.fetch_n && !ctrl_q) begin
         mpv_d = 1'b0;
      end
      irq_d   = flag_d;
      allow_d = (ind_d == INDIRECT_LIMIT);
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ind_q <= INDIRECT_RESET;
         ctrl_q <= 1'b0;
         flag_q <= 1'b0;
         flagb_q <= 1'b0;
         paren_q <= 1'b1;
         parerr_q <= 1'b0;
         vio15_q <= 1'b0;
         evr_q <= 1'b1;
         mpv_q <= 1'b0;
         meflg_q <= 1'b0;
         jsb_q <= 1'b0;
         iogsel_q <= 1'b0;
         rd_q <= 1'b0;
         pci_q <= 1'b0;
         resp_q <= 1'b0;
         skip_q <= 1'b0;
         irq_q <= 1'b0;
         allow_q <= 1'b0;
         fence_q <= FENCE_RESET;
         mpvr_q <= FENCE_RESET;
         pvr_q <= FENCE_RESET;
         sout_q <= 16'h0000;
      end else begin
         ind_q <= ind_d;
         ctrl_q <= ctrl_d;
         flag_q <= flag_d;
         flagb_q <= flagb_d;
         paren_q <= paren_d;
         parerr_q <= parerr_d;
         vio15_q <= vio15_d;
         evr_q <= evr_d;
         mpv_q <= mpv_d;
         meflg_q <= meflg_d;
         jsb_q <= jsb_d;
         iogsel_q <= iogsel_d;
         rd_q <= rd_d;
         pci_q <= pci_d;
         resp_q <= resp_d;
         skip_q <= skip_d;
         irq_q <= irq_d;
         allow_q <= allow_d;
         fence_q <= fence_d;
         mpvr_q <= mpvr_d;
         pvr_q <= pvr_d;
         sout_q <= sout_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status outputs are ground-true except skip and parity_enable_o
   assign link.control_n                   = !ctrl_q;
   assign link.flag_n                      = !flag_q;
   assign link.irq_n                       = !irq_q;
   assign link.protect_check_in_progress_n = !pci_q;
   assign link.indirect_interrupt_allow_n  = !allow_q;
   assign link.violation_n                 = !mpv_q;
   assign link.clear_parity_indicator_n    = !resp_q;
   assign link.skip_flag                   = skip_q;
   assign link.s_bus_out                   = sout_q;
   assign fence_o                          = fence_q;
   assign parity_enable_o                  = paren_q;
endmodule

// ===== mp_host.sv
/*
 CPU / memory / MEMORY_MANAGEMENT_UNIT end driving the protect option link.
 Assumes user side issues one request at a time; strobes are registered.
*/
`timescale 1ns/100ps
module mp_host (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   mp_link_if.host          link,
   input  wire logic        fetch_i,
   input  wire logic        indirect_i,
   input  wire logic        io_special_i,
   input  wire logic        ir_store_i,
   input  wire logic        mmu_violation_i,
   input  wire logic        check_i,
   input  wire logic        parity_error_i,
   input  wire logic        mem_read_i,
   input  wire logic        dma_freeze_i,
   input  wire logic        int_ack_i,
   input  wire logic        halt_on_parity_i,
   input  wire logic [2:0]  io_cmd_i,
   input  wire logic [5:0]  io_select_i,
   input  wire logic [14:0] m_bus_i,
   input  wire logic [15:0] s_bus_i,
   output logic [15:0]      read_data_o,
   output logic             violation_o,
   output logic             flag_o,
   output logic             skip_o,
   output logic             allow_int_o
);
   import mp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [10:0] str_q, str_d;
   logic [2:0]  cmd_q, cmd_d;
   logic [5:0]  sel_q, sel_d;
   logic [14:0] m_q, m_d;
   logic [15:0] s_q, s_d, rd_q, rd_d;
   logic [3:0]  st_q, st_d;

   always_comb begin
      // Registered level copies; each strobe lasts as long as the user side holds its input
      str_d = {halt_on_parity_i, int_ack_i, dma_freeze_i, mem_read_i, parity_error_i,
               check_i, mmu_violation_i, ir_store_i, io_special_i, indirect_i, fetch_i};
      cmd_d = io_cmd_i;
      sel_d = io_select_i;
      m_d   = m_bus_i;
      s_d   = s_bus_i;
      rd_d  = link.s_bus_out;
      st_d  = {!link.violation_n, !link.flag_n, link.skip_flag,
               !link.indirect_interrupt_allow_n};
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         str_q <= 11'h000;
         cmd_q <= 3'h0;
         sel_q <= 6'h00;
         m_q   <= 15'h0000;
         s_q   <= 16'h0000;
         rd_q  <= 16'h0000;
         st_q  <= 4'h0;
      end else begin
         str_q <= str_d;
         cmd_q <= cmd_d;
         sel_q <= sel_d;
         m_q   <= m_d;
         s_q   <= s_d;
         rd_q  <= rd_d;
         st_q  <= st_d;
      end
   end

   assign link.fetch_n                = !str_q[0];
   assign link.indirect_inc_n         = !str_q[1];
   assign link.io_group_special_n     = !str_q[2];
   assign link.ir_store_n             = !str_q[3];
   assign link.mem_exp_violation_n    = !str_q[4];
   assign link.protect_check_strobe_n = !str_q[5];
   assign link.parity_error_n         = !str_q[6];
   assign link.mem_read_n             = !str_q[7];
   assign link.dma_freeze_in_n        = !str_q[8];
   assign link.int_ack_n              = !str_q[9];
   assign link.halt_on_parity_n       = !str_q[10];
   assign link.io_cmd                 = cmd_q;
   assign link.io_select              = sel_q;
   assign link.m_bus                  = m_q;
   assign link.s_bus_in               = s_q;
   assign read_data_o                 = rd_q;
   assign violation_o                 = st_q[3];
   assign flag_o                      = st_q[2];
   assign skip_o                      = st_q[1];
   assign allow_int_o                 = st_q[0];
endmodule

// ===== mp_chk.sv
/*
 Checker for the protect option link, beside the link that joins both ends.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module mp_chk
   import mp_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic       fetch_n,
   input wire logic       indirect_inc_n,
   input wire logic       halt_on_parity_n,
   input wire logic       protect_check_strobe_n,
   input wire logic       parity_error_n,
   input wire logic       int_ack_n,
   input wire logic [2:0] io_cmd,
   input wire logic [5:0] io_select,
   input wire logic       control_n,
   input wire logic       flag_n,
   input wire logic       irq_n,
   input wire logic       protect_check_in_progress_n,
   input wire logic       indirect_interrupt_allow_n,
   input wire logic       violation_n,
   input wire logic       clear_parity_indicator_n,
   input wire logic       skip_flag
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence ack_taken;
      !int_ack_n && !irq_n;
   endsequence
   sequence clear_pulse;
      !clear_parity_indicator_n ##1 clear_parity_indicator_n;
   endsequence
   AST_ALLOW_AFTER_THREE: assert property (
      (fetch_n && int_ack_n && !indirect_inc_n)[*3] |=> !indirect_interrupt_allow_n)
      else $error("allow not raised after three indirect levels");
   AST_FETCH_CLEARS_COUNT: assert property (
      !fetch_n && indirect_inc_n |=> indirect_interrupt_allow_n)
      else $error("fetch did not clear indirect count");
   AST_CHECK_IN_PROGRESS: assert property (
      protect_check_in_progress_n == $past(protect_check_strobe_n))
      else $error("check in progress does not follow strobe");
   AST_ACK_CLEARS: assert property (
      ack_taken |=> flag_n && irq_n && violation_n && control_n)
      else $error("acknowledge did not clear flag state");
   AST_ACK_PARITY_PULSE: assert property (
      ack_taken |=> clear_pulse)
      else $error("no single parity clear pulse after acknowledge");
   AST_PARITY_PULSE_CAUSE: assert property (
      $fell(clear_parity_indicator_n) |-> !$past(int_ack_n) && !$past(irq_n))
      else $error("parity clear pulse without acknowledge");
   AST_SET_CONTROL: assert property (
      io_cmd == IO_SET_CTRL && io_select == SELECT_CODE && (int_ack_n || irq_n)
      |=> !control_n)
      else $error("set control not shown");
   AST_SKIP_CAUSE: assert property (
      skip_flag |-> $past(io_select) == SELECT_CODE &&
      ($past(io_cmd) == IO_SKIP_SET || $past(io_cmd) == IO_SKIP_CLR))
      else $error("skip without own skip command");
   AST_NO_VIOLATION_UNPROTECTED: assert property (
      control_n && violation_n |=> violation_n)
      else $error("violation while control clear");
   AST_HALT_BLOCKS_PARITY: assert property (
      !halt_on_parity_n && !parity_error_n && flag_n && control_n && io_cmd == IO_NONE
      |=> flag_n)
      else $error("parity flag raised while halting on parity");
endmodule

// ===== memory_protect_parity_unit_tb.sv
/*
 Testbench: host end and device end joined by the link, driven from the
 host user side. Assumes one clock in and one clock out at the host end.
*/
`timescale 1ns/100ps
module memory_protect_parity_unit_tb;
   import mp_pkg::*;
   logic        clk_i;
   logic        reset_i;
   logic [10:0] st;
   io_cmd_type  cmd;
   logic [5:0]  sel;
   logic [14:0] mb;
   logic [15:0] sb;
   logic [15:0] rd;
   logic        viol, flg, skp, alw, pen, sk;
   logic [14:0] fence;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   mp_link_if link ();
   mp_device mp_device_i (.clk_i, .reset_i, .link, .fence_o(fence), .parity_enable_o(pen));
   mp_host mp_host_i (.clk_i, .reset_i, .link, .fetch_i(st[0]), .indirect_i(st[1]),
      .io_special_i(st[2]), .ir_store_i(st[3]), .mmu_violation_i(st[4]), .check_i(st[5]),
      .parity_error_i(st[6]), .mem_read_i(st[7]), .dma_freeze_i(st[8]), .int_ack_i(st[9]),
      .halt_on_parity_i(st[10]), .io_cmd_i(cmd), .io_select_i(sel), .m_bus_i(mb),
      .s_bus_i(sb), .read_data_o(rd), .violation_o(viol), .flag_o(flg), .skip_o(skp),
      .allow_int_o(alw));
   mp_chk mp_chk_i (.clk_i, .reset_i, .fetch_n(link.fetch_n),
      .indirect_inc_n(link.indirect_inc_n), .halt_on_parity_n(link.halt_on_parity_n),
      .protect_check_strobe_n(link.protect_check_strobe_n),
      .parity_error_n(link.parity_error_n), .int_ack_n(link.int_ack_n),
      .io_cmd(link.io_cmd), .io_select(link.io_select), .control_n(link.control_n),
      .flag_n(link.flag_n), .irq_n(link.irq_n),
      .protect_check_in_progress_n(link.protect_check_in_progress_n),
      .indirect_interrupt_allow_n(link.indirect_interrupt_allow_n),
      .violation_n(link.violation_n),
      .clear_parity_indicator_n(link.clear_parity_indicator_n),
      .skip_flag(link.skip_flag));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Whole run is a few hundred cycles; the ceiling leaves ample margin
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         summarize();
      end
   end
   task automatic chk_bit(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Three falling edges after release cover link, device and host-copy stages
   task automatic pulse(input int b, input int n);
      st[b] = 1'b1;
      repeat (n) @(negedge clk_i);
      st[b] = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask
   // Skip pulse stands one cycle at the host output, so it is caught there
   task automatic io(input io_cmd_type c, input logic [5:0] s);
      cmd = c;
      sel = s;
      @(negedge clk_i);
      cmd = IO_NONE;
      repeat (2) @(negedge clk_i);
      sk = skp;
      @(negedge clk_i);
   endtask
   task automatic summarize();
      $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      st = '0;
      cmd = IO_NONE;
      sel = 6'h00;
      mb = 15'h0000;
      sb = 16'h0000;
      reset_i = 1'b1;
      repeat (3) @(negedge clk_i);
      reset_i = 1'b0;
      @(negedge clk_i);
      chk_bit("parity_enable", 1'b1, pen);
      chk_word("fence", {1'b0, FENCE_RESET}, {1'b0, fence});
      io(IO_SKIP_SET, SELECT_CODE);
      chk_bit("skip_set", 1'b0, sk);
      io(IO_SKIP_CLR, SELECT_CODE);
      chk_bit("skip_clr", 1'b1, sk);
      io(IO_SKIP_CLR, 6'h04);
      chk_bit("skip_other_code", 1'b0, sk);
      mb = 15'h1234;
      pulse(0, 1);
      io(IO_READ_VIO, SELECT_CODE);
      chk_word("read_fetch", 16'h1234, rd);
      mb = 15'h0321;
      pulse(0, 1);
      io(IO_READ_VIO, 6'h06);
      chk_word("read_other_code", 16'h1234, rd);
      io(IO_READ_VIO, SELECT_CODE);
      chk_word("read_track", 16'h0321, rd);
      pulse(1, 2);
      chk_bit("allow_two", 1'b0, alw);
      pulse(1, 1);
      chk_bit("allow_three", 1'b1, alw);
      pulse(0, 1);
      chk_bit("allow_fetch", 1'b0, alw);
      pulse(1, 3);
      chk_bit("allow_burst", 1'b1, alw);
      st[10] = 1'b1;
      pulse(6, 1);
      chk_bit("flag_halt", 1'b0, flg);
      chk_bit("parity_en_halt", 1'b1, pen);
      st[10] = 1'b0;
      sb = 16'h0100;
      io(IO_LOAD_FNC, SELECT_CODE);
      chk_word("fence_load", 16'h0100, {1'b0, fence});
      // Pass 0 plain instruction (bound 2), pass 1 subroutine-call form (bound 0)
      for (int i = 0; i < 2; i++) begin
         io(IO_SET_CTRL, SELECT_CODE);
         sb = i ? 16'h1800 : 16'h0000;
         mb = 15'h0040;
         pulse(0, 1);
         pulse(3, 1);
         mb = 15'h0100;
         pulse(5, 1);
         chk_bit("viol_at_fence", 1'b0, viol);
         mb = i ? 15'h0000 : 15'h0001;
         pulse(5, 1);
         chk_bit("viol_low_bound", i[0], viol);
         mb = 15'h00ff;
         pulse(5, 1);
         chk_bit("viol", 1'b1, viol);
         chk_bit("flag", 1'b1, flg);
         mb = 15'h0555;
         pulse(0, 1);
         io(IO_READ_VIO, SELECT_CODE);
         chk_word("read_frozen", 16'h0040, rd);
         pulse(9, 1);
         chk_bit("flag_ack", 1'b0, flg);
         chk_bit("viol_ack", 1'b0, viol);
      end
      // I/O instruction in the register, then I/O special to various select codes
      io(IO_SET_CTRL, SELECT_CODE);
      sb = 16'h8400;
      mb = 15'h0200;
      pulse(0, 1);
      st[8] = 1'b1;
      pulse(3, 1);
      st[8] = 1'b0;
      sel = 6'h07;
      pulse(2, 1);
      chk_bit("viol_io_frozen", 1'b0, viol);
      pulse(3, 1);
      sel = 6'h01;
      pulse(2, 1);
      chk_bit("viol_io_code1", 1'b0, viol);
      sel = 6'h07;
      pulse(2, 1);
      chk_bit("viol_io", 1'b1, viol);
      io(IO_READ_VIO, SELECT_CODE);
      chk_word("read_io", 16'h0200, rd);
      pulse(9, 1);
      chk_bit("flag_io_ack", 1'b0, flg);
      mb = 15'h0123;
      pulse(7, 1);
      pulse(6, 1);
      chk_bit("parity_en_err", 1'b0, pen);
      mb = 15'h0456;
      pulse(7, 1);
      io(IO_READ_VIO, SELECT_CODE);
      chk_word("read_parity", 16'h8123, rd);
      mb = 15'h0789;
      pulse(6, 1);
      io(IO_READ_VIO, SELECT_CODE);
      chk_word("read_parity_held", 16'h8123, rd);
      pulse(9, 1);
      chk_bit("flag_parity_ack", 1'b0, flg);
      io(IO_SET_FLAG, SELECT_CODE);
      chk_bit("parity_en_set", 1'b1, pen);
      io(IO_CLR_FLAG, SELECT_CODE);
      chk_bit("parity_en_clr", 1'b0, pen);
      pulse(6, 1);
      chk_bit("flag_parity_off", 1'b0, flg);
      // Expansion-unit violation with protection off: recorded for skip, no violation out
      pulse(4, 1);
      chk_bit("viol_mmu_ctrl_off", 1'b0, viol);
      io(IO_SKIP_SET, SELECT_CODE);
      chk_bit("skip_set_mmu", 1'b1, sk);
      io(IO_SKIP_CLR, SELECT_CODE);
      chk_bit("skip_clr_mmu", 1'b0, sk);
      summarize();
   end
endmodule
